/* File: hdl/eba_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module eba_sync
  import eba_pkg::*;
#(
  parameter int unsigned W = SYNC_W
) (
  input  wire logic  i_clk,
  input  wire logic  i_rst_n,
  eba_sync_if.snk    bus
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser, one chain per bit
  // ----------------------------------------------------------------
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_comb begin
        meta_d[g] = bus.raw[g];
        sync_d[g] = meta_q[g];
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta_q <= W'(SYNC_RST);
      sync_q <= W'(SYNC_RST);
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign bus.sync = sync_q;

endmodule
`default_nettype wire

/* File: hdl/eba_top.sv */
`timescale 1ns/1ps
`default_nettype none
module eba_top
  import eba_pkg::*;
#(
  parameter int unsigned N_CHAN = NUM_CHAN
) (
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST_N,
  input  wire logic [INDEX_W-1:0]  I_PROCESSOR_INDEX,
  input  wire logic                I_BUS_MASTER,
  input  wire logic                I_HOST_REQUEST_IN_N,
  input  wire logic                I_HOST_GRANT_IN_N,
  output var  logic                O_HOST_GRANT_OUT_N,
  output var  logic                O_HOST_GRANT_OE,
  output var  logic                O_HOST_OWNS_BUS,
  input  wire logic                I_CORE_PRIORITY_LINE_N,
  output var  logic                O_CORE_PRIORITY_LINE_N,
  output var  logic                O_CORE_PRIORITY_OE,
  input  wire logic                I_DMA_PRIORITY_LINE_N,
  output var  logic                O_DMA_PRIORITY_LINE_N,
  output var  logic                O_DMA_PRIORITY_OE,
  output var  logic                O_PULLUP_EN,
  input  wire logic [N_CHAN-1:0]   I_EXT_DMA_REQUEST_N,
  input  wire logic [N_CHAN-1:0]   I_CHAN_INIT,
  input  wire logic [N_CHAN-1:0]   I_CHAN_FLYBY,
  input  wire logic [N_CHAN-1:0]   I_CHAN_HIPRI,
  input  wire logic                I_CORE_REQ,
  input  wire logic                I_XFER_DONE,
  output logic                     O_CORE_GNT,
  output logic [N_CHAN-1:0]        O_DMA_GNT,
  output var  logic                O_BUS_OE,
  output var  logic                O_SDRAM_SELF_REFRESH,
  output var  logic                O_FLYBY_N,
  output var  logic                O_IO_OUTPUT_ENABLE_N,
  output logic                     O_YIELD_BUS
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [CHAN_W-1:0] lowest_set(
    input logic [N_CHAN-1:0] v
  );
    logic [CHAN_W-1:0] idx;
    idx = '0;
    for (int i = N_CHAN - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = CHAN_W'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  eba_sync_if #(.W(SYNC_W)) sync_bus ();

  always_comb begin
    sync_bus.raw = {I_DMA_PRIORITY_LINE_N,
                    I_CORE_PRIORITY_LINE_N,
                    SYNC_CPA'(I_EXT_DMA_REQUEST_N)};
  end

  eba_sync #(
    .W(SYNC_W)
  ) u_sync (
    .i_clk   (I_REF_CLK),
    .i_rst_n (I_RST_N),
    .bus     (sync_bus)
  );

  logic [N_CHAN-1:0] req_lvl;
  logic              cpa_low;
  logic              dpa_low;

  always_comb begin
    req_lvl = ~sync_bus.sync[N_CHAN-1:0];
    cpa_low = ~sync_bus.sync[SYNC_CPA];
    dpa_low = ~sync_bus.sync[SYNC_DPA];
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  eba_state_t               state_q;
  eba_state_t               state_d;
  logic [CHAN_W-1:0]        chan_q;
  logic [CHAN_W-1:0]        chan_d;
  logic [SREF_CNT_W-1:0]    cnt_q;
  logic [SREF_CNT_W-1:0]    cnt_d;
  logic [N_CHAN-1:0]        pend_q;
  logic [N_CHAN-1:0]        pend_d;
  logic [N_CHAN-1:0]        req_prev_q;
  logic [N_CHAN-1:0]        req_prev_d;
  logic [OWN_MASK_CYC-1:0]  cpa_own_q;
  logic [OWN_MASK_CYC-1:0]  cpa_own_d;
  logic [OWN_MASK_CYC-1:0]  dpa_own_q;
  logic [OWN_MASK_CYC-1:0]  dpa_own_d;

  logic              host_req;
  logic              remote_cpa;
  logic              remote_dpa;
  logic [N_CHAN-1:0] req_rise;
  logic [N_CHAN-1:0] dma_ok;
  logic              cpa_drive;
  logic              dpa_drive;

  // ----------------------------------------------------------------
  // Shared priority lines
  // ----------------------------------------------------------------
  always_comb begin
    host_req = ~I_HOST_REQUEST_IN_N;
    req_rise = req_lvl & ~req_prev_q;
    // Own pull-down is echoed back; mask it while it propagates
    remote_cpa = cpa_low & ~(|cpa_own_q);
    remote_dpa = dpa_low & ~(|dpa_own_q);
    cpa_drive = I_CORE_REQ | (state_q == ST_CORE);
    // pull while a high-priority DMA request is pending
    dpa_drive = |(pend_q & I_CHAN_INIT & I_CHAN_HIPRI);
    cpa_own_d = {cpa_own_q[OWN_MASK_CYC-2:0], cpa_drive};
    dpa_own_d = {dpa_own_q[OWN_MASK_CYC-2:0], dpa_drive};
    req_prev_d = req_lvl;
  end

  // ----------------------------------------------------------------
  // DMA eligibility
  // ----------------------------------------------------------------
  always_comb begin
    dma_ok = pend_q & I_CHAN_INIT;
    // remote core access holds off all DMA
    if (remote_cpa) begin
      dma_ok = '0;
    end
    // remote high-priority DMA holds off normal DMA
    if (remote_dpa) begin
      dma_ok = dma_ok & I_CHAN_HIPRI;
    end
  end

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    cnt_d   = cnt_q;
    pend_d  = pend_q;
    if (state_q == ST_DMA && I_XFER_DONE) begin
      pend_d[chan_q] = 1'b0;
    end
    // others kept; a new request beats the clear
    pend_d = pend_d | (req_rise & I_CHAN_INIT);
    case (state_q)
      ST_IDLE: begin
        if (I_BUS_MASTER) begin
          if (host_req) begin
            state_d = ST_SREF;
            cnt_d   = SREF_CNT_W'(SREF_CYCLES - 1);
          end else if (I_CORE_REQ) begin
            state_d = ST_CORE;
          end else if (|dma_ok) begin
            state_d = ST_DMA;
            chan_d  = lowest_set(dma_ok);
          end
        end
      end
      ST_CORE, ST_DMA: begin
        // switch only at a transaction boundary
        if (I_XFER_DONE) begin
          state_d = ST_IDLE;
        end
      end
      ST_SREF: begin
        if (cnt_q == '0) begin
          state_d = ST_HOST;
        end else begin
          cnt_d = cnt_q - SREF_CNT_W'(1);
        end
      end
      ST_HOST: begin
        if (!host_req) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      state_q    <= ST_IDLE;
      chan_q     <= '0;
      cnt_q      <= '0;
      pend_q     <= N_CHAN'(PEND_RST);
      req_prev_q <= '0;
      cpa_own_q  <= '0;
      dpa_own_q  <= '0;
    end else begin
      state_q    <= state_d;
      chan_q     <= chan_d;
      cnt_q      <= cnt_d;
      pend_q     <= pend_d;
      req_prev_q <= req_prev_d;
      cpa_own_q  <= cpa_own_d;
      dpa_own_q  <= dpa_own_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin outputs
  // ----------------------------------------------------------------
  logic hg_n_q;
  logic hg_n_d;
  logic hg_oe_q;
  logic hg_oe_d;
  logic host_owns_q;
  logic host_owns_d;
  logic cpa_oe_q;
  logic dpa_oe_q;
  logic pu_q;
  logic pu_d;
  logic bus_oe_q;
  logic bus_oe_d;
  logic sref_q;
  logic sref_d;
  logic flyby_n_q;
  logic flyby_n_d;
  logic io_output_enable_n_q;
  logic io_output_enable_n_d;
  logic flyby_next;

  always_comb begin
    hg_n_d = ~(state_d == ST_HOST);
    // the master drives the grant, and so does a part whose next state is ST_HOST
    hg_oe_d = I_BUS_MASTER | (state_d == ST_HOST);
    host_owns_d = ~I_HOST_GRANT_IN_N;
    pu_d = (I_PROCESSOR_INDEX == PULLUP_INDEX);
    // float bus outputs while host holds bus
    bus_oe_d = I_BUS_MASTER & (state_d != ST_HOST);
    sref_d = (state_d == ST_SREF) | (state_d == ST_HOST);
    flyby_next = (state_d == ST_DMA) & I_CHAN_FLYBY[chan_d];
    // device turns the next word in one cycle
    flyby_n_d = ~flyby_next;
    io_output_enable_n_d = ~flyby_next;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_N) begin
      hg_n_q      <= 1'b1;
      hg_oe_q     <= 1'b0;
      host_owns_q <= 1'b0;
      cpa_oe_q    <= 1'b0;
      dpa_oe_q    <= 1'b0;
      pu_q        <= 1'b0;
      bus_oe_q    <= 1'b0;
      sref_q      <= 1'b0;
      flyby_n_q   <= 1'b1;
      io_output_enable_n_q    <= 1'b1;
    end else begin
      hg_n_q      <= hg_n_d;
      hg_oe_q     <= hg_oe_d;
      host_owns_q <= host_owns_d;
      cpa_oe_q    <= cpa_drive;
      dpa_oe_q    <= dpa_drive;
      pu_q        <= pu_d;
      bus_oe_q    <= bus_oe_d;
      sref_q      <= sref_d;
      flyby_n_q   <= flyby_n_d;
      io_output_enable_n_q    <= io_output_enable_n_d;
    end
  end

  always_comb begin
    O_HOST_GRANT_OUT_N   = hg_n_q;
    O_HOST_GRANT_OE      = hg_oe_q;
    O_HOST_OWNS_BUS      = host_owns_q;
    O_CORE_PRIORITY_LINE_N = 1'b0;
    O_CORE_PRIORITY_OE     = cpa_oe_q;
    O_DMA_PRIORITY_LINE_N  = 1'b0;
    O_DMA_PRIORITY_OE      = dpa_oe_q;
    O_PULLUP_EN          = pu_q;
    O_BUS_OE             = bus_oe_q;
    O_SDRAM_SELF_REFRESH = sref_q;
    O_FLYBY_N            = flyby_n_q;
    O_IO_OUTPUT_ENABLE_N = io_output_enable_n_q;
    O_CORE_GNT           = (state_q == ST_CORE);
    O_DMA_GNT            = '0;
    if (state_q == ST_DMA) begin
      O_DMA_GNT[chan_q] = 1'b1;
    end
    // master idle and a slave core waits
    O_YIELD_BUS = I_BUS_MASTER & (state_q == ST_IDLE) & remote_cpa
                  & ~I_CORE_REQ & ~host_req;
  end

endmodule
`default_nettype wire

/* File: include/eba_pkg.sv */
package eba_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_CHAN    = 4;
  localparam int unsigned CHAN_W      = 2;
  localparam int unsigned INDEX_W     = 3;
  localparam int unsigned SYNC_STAGES = 2;
  // Four request pins plus the two shared priority lines
  localparam int unsigned SYNC_W      = 6;
  localparam int unsigned SYNC_CPA    = 4;
  localparam int unsigned SYNC_DPA    = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 50;
  // Time given to the self-refresh command before the grant
  localparam int unsigned SREF_LEAD_NS   = 100;
  localparam int unsigned SREF_CYC_RAW   =
    (SREF_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SREF_CYCLES    =
    (SREF_CYC_RAW < 1) ? 1 : SREF_CYC_RAW;
  localparam int unsigned SREF_CNT_W     = 4;
  // Cycles that own drive of a shared line masks its sampled value
  localparam int unsigned OWN_MASK_CYC   = SYNC_STAGES + 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [SYNC_W-1:0]   SYNC_RST     = 6'h3F;
  localparam logic [NUM_CHAN-1:0] PEND_RST     = 4'h0;
  localparam logic [INDEX_W-1:0]  PULLUP_INDEX = 3'h0;

  // ----------------------------------------------------------------
  // Arbiter states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CORE,
    ST_DMA,
    ST_SREF,
    ST_HOST
  } eba_state_t;

endpackage

/* File: include/eba_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface eba_sync_if #(
  parameter int unsigned W = 6
);
  logic [W-1:0] raw;
  logic [W-1:0] sync;

  modport src (output raw, input  sync);
  modport snk (input  raw, output sync);
endinterface
`default_nettype wire

/* File: tb/eba_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module eba_far_end (
  input  wire logic  i_clk,
  input  wire logic  i_slow,
  input  wire logic  i_peer_core,
  input  wire logic  i_peer_dma,
  input  wire logic  i_grant_n,
  input  wire logic  i_grant_oe,
  input  wire logic  i_core_oe,
  input  wire logic  i_dma_oe,
  input  wire logic  i_busy,
  output logic       o_grant_n,
  output logic       o_core_n,
  output logic       o_dma_n,
  output logic       o_done
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       done_q;
  logic       done_d;
  assign o_core_n = !(i_core_oe || i_peer_core);
  assign o_dma_n = !(i_dma_oe || i_peer_dma);
  assign o_grant_n = i_grant_oe ? i_grant_n : 1'b1;
  assign o_done = done_q;
  always_comb begin
    cnt_d = (i_busy && !done_q) ? cnt_q + 3'h1 : 3'h0;
    done_d = i_busy && !done_q && (cnt_q == (i_slow ? 3'h4 : 3'h0));
  end
  always_ff @(posedge i_clk) begin
    cnt_q <= cnt_d;
    done_q <= done_d;
  end
endmodule
`default_nettype wire

/* File: tb/eba_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module eba_top_monitor
  import eba_pkg::*;
#(
  parameter int unsigned N_CHAN = NUM_CHAN
) (
  input  wire logic                I_REF_CLK,
  input  wire logic                I_RST_N,
  input  wire logic [INDEX_W-1:0]  I_PROCESSOR_INDEX,
  input  wire logic                I_HOST_REQUEST_IN_N,
  input  wire logic                I_HOST_GRANT_IN_N,
  input  wire logic                I_CORE_REQ,
  input  wire logic [N_CHAN-1:0]   I_CHAN_INIT,
  input  wire logic                O_HOST_GRANT_OUT_N,
  input  wire logic                O_HOST_OWNS_BUS,
  input  wire logic                O_CORE_PRIORITY_LINE_N,
  input  wire logic                O_CORE_PRIORITY_OE,
  input  wire logic                O_DMA_PRIORITY_LINE_N,
  input  wire logic                O_PULLUP_EN,
  input  wire logic                O_CORE_GNT,
  input  wire logic [N_CHAN-1:0]   O_DMA_GNT,
  input  wire logic                O_BUS_OE,
  input  wire logic                O_SDRAM_SELF_REFRESH,
  input  wire logic                O_FLYBY_N,
  input  wire logic                O_IO_OUTPUT_ENABLE_N
);
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  a_bus_float: assert property (!O_HOST_GRANT_OUT_N |->
    !O_BUS_OE && O_SDRAM_SELF_REFRESH) else $error("bus driven in grant");
  a_sref_lead: assert property ($fell(O_HOST_GRANT_OUT_N) |->
    O_SDRAM_SELF_REFRESH && $past(O_SDRAM_SELF_REFRESH))
    else $error("grant before refresh");
  a_grant_hold: assert property (!O_HOST_GRANT_OUT_N &&
    !I_HOST_REQUEST_IN_N |=> !O_HOST_GRANT_OUT_N) else $error("grant dropped");
  a_grant_monitor: assert property (1'b1 |=> O_HOST_OWNS_BUS ==
    !$past(I_HOST_GRANT_IN_N)) else $error("grant monitor wrong");
  a_core_drive: assert property (I_CORE_REQ |=>
    O_CORE_PRIORITY_OE) else $error("core line not pulled");
  a_open_drain: assert property (O_CORE_PRIORITY_LINE_N == 1'b0 &&
    O_DMA_PRIORITY_LINE_N == 1'b0) else $error("line driven high");
  a_pullup_index: assert property (1'b1 |=> O_PULLUP_EN ==
    ($past(I_PROCESSOR_INDEX) == 3'h0)) else $error("pull-up wrong");
  a_io_output_enable_flyby: assert property (!O_IO_OUTPUT_ENABLE_N |->
    !O_FLYBY_N && O_DMA_GNT != '0) else $error("io enable outside flyby");
  a_init_only: assert property ((O_DMA_GNT & ~I_CHAN_INIT) == '0)
    else $error("grant on idle channel");

  c_host: cover property ($fell(O_HOST_GRANT_OUT_N));
  c_core: cover property ($rose(O_CORE_GNT));
  c_flyby: cover property ($fell(O_FLYBY_N));
endmodule

bind eba_top eba_top_monitor #(.N_CHAN(N_CHAN)) u_mon (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
  .I_PROCESSOR_INDEX(I_PROCESSOR_INDEX),
  .I_HOST_REQUEST_IN_N(I_HOST_REQUEST_IN_N),
  .I_HOST_GRANT_IN_N(I_HOST_GRANT_IN_N), .I_CORE_REQ(I_CORE_REQ),
  .I_CHAN_INIT(I_CHAN_INIT), .O_HOST_GRANT_OUT_N(O_HOST_GRANT_OUT_N),
  .O_HOST_OWNS_BUS(O_HOST_OWNS_BUS),
  .O_CORE_PRIORITY_LINE_N(O_CORE_PRIORITY_LINE_N),
  .O_CORE_PRIORITY_OE(O_CORE_PRIORITY_OE),
  .O_DMA_PRIORITY_LINE_N(O_DMA_PRIORITY_LINE_N),
  .O_PULLUP_EN(O_PULLUP_EN), .O_CORE_GNT(O_CORE_GNT), .O_DMA_GNT(O_DMA_GNT),
  .O_BUS_OE(O_BUS_OE), .O_SDRAM_SELF_REFRESH(O_SDRAM_SELF_REFRESH),
  .O_FLYBY_N(O_FLYBY_N), .O_IO_OUTPUT_ENABLE_N(O_IO_OUTPUT_ENABLE_N)
);
`default_nettype wire

/* File: tb/eba_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module eba_top_tb;
  import eba_pkg::*;
  logic clk, rst_n, master, hreq_n, core_req, slow, peer_c, peer_d;
  logic [INDEX_W-1:0] idx;
  logic [3:0] dreq_n;
  logic grant_n, grant_oe, gin_n, cl_n, dl_n, cpo, dpo, pull, cgnt;
  logic bus_oe, sref, fly_n, io_output_enable_n, done, busy, yield;
  logic [3:0] dgnt;
  int failures = 0;
  int cmp_count = 0;

  eba_top dut (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_PROCESSOR_INDEX(idx),
    .I_BUS_MASTER(master), .I_HOST_REQUEST_IN_N(hreq_n),
    .I_HOST_GRANT_IN_N(gin_n), .O_HOST_GRANT_OUT_N(grant_n),
    .O_HOST_GRANT_OE(grant_oe), .O_HOST_OWNS_BUS(),
    .I_CORE_PRIORITY_LINE_N(cl_n), .O_CORE_PRIORITY_LINE_N(),
    .O_CORE_PRIORITY_OE(cpo), .I_DMA_PRIORITY_LINE_N(dl_n),
    .O_DMA_PRIORITY_LINE_N(), .O_DMA_PRIORITY_OE(dpo), .O_PULLUP_EN(pull),
    .I_EXT_DMA_REQUEST_N(dreq_n), .I_CHAN_INIT(4'hB), .I_CHAN_FLYBY(4'h2),
    .I_CHAN_HIPRI(4'h8), .I_CORE_REQ(core_req), .I_XFER_DONE(done),
    .O_CORE_GNT(cgnt), .O_DMA_GNT(dgnt), .O_BUS_OE(bus_oe),
    .O_SDRAM_SELF_REFRESH(sref), .O_FLYBY_N(fly_n),
    .O_IO_OUTPUT_ENABLE_N(io_output_enable_n), .O_YIELD_BUS(yield)
  );
  assign busy = cgnt || (dgnt != 4'h0);
  eba_far_end u_far (
    .i_clk(clk), .i_slow(slow), .i_peer_core(peer_c), .i_peer_dma(peer_d),
    .i_grant_n(grant_n), .i_grant_oe(grant_oe), .i_core_oe(cpo),
    .i_dma_oe(dpo), .i_busy(busy), .o_grant_n(gin_n), .o_core_n(cl_n),
    .o_dma_n(dl_n), .o_done(done)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    $display("compares=%0d mismatches=%0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wait_g(input logic [4:0] g);
    int n;
    n = 0;
    while ({cgnt, dgnt} !== g) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 30) begin
        failures++;
        end_sim();
      end
    end
  endtask

  task automatic dpulse(input int ch);
    @(posedge clk) dreq_n[ch] <= 1'b0;
    repeat (3) @(posedge clk);
    dreq_n[ch] <= 1'b1;
  endtask

  task automatic do_reset(input logic [2:0] id);
    rst_n <= 1'b0;
    idx <= id;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(pull, id == 3'h0);
  endtask

  task automatic t_host();
    int n;
    n = 0;
    @(posedge clk) hreq_n <= 1'b0;
    while (grant_n !== 1'b0 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n[7:0], 8'h03);
    if (n == 20) end_sim();
    chk({bus_oe, sref}, 2'b01);
    repeat (6) @(posedge clk);
    #1 chk(grant_n, 1'b0);
    @(posedge clk) hreq_n <= 1'b1;
    #1 chk(grant_n, 1'b0);
    repeat (3) @(posedge clk);
    #1 chk({grant_n, bus_oe}, 2'b11);
    $display("host grant test done");
  endtask

  task automatic t_slave();
    @(posedge clk) master <= 1'b0;
    hreq_n <= 1'b0;
    repeat (8) @(posedge clk);
    #1 chk({grant_oe, grant_n}, 2'b01);
    @(posedge clk) hreq_n <= 1'b1;
    master <= 1'b1;
    $display("slave grant test done");
  endtask

  task automatic t_dma();
    dpulse(1);
    wait_g(5'h02);
    chk({fly_n, io_output_enable_n}, 2'b00);
    dpulse(0);
    wait_g(5'h01);
    chk({fly_n, io_output_enable_n}, 2'b11);
    dpulse(2);
    repeat (8) @(posedge clk);
    #1 chk(dgnt, 4'h0);
    $display("dma flyby test done");
  endtask

  task automatic t_prio();
    @(posedge clk) peer_c <= 1'b1;
    dpulse(0);
    repeat (8) @(posedge clk);
    #1 chk(dgnt, 4'h0);
    chk(yield, 1'b1);
    @(posedge clk) peer_c <= 1'b0;
    wait_g(5'h01);
    @(posedge clk) peer_d <= 1'b1;
    dpulse(3);
    wait_g(5'h08);
    chk(dpo, 1'b1);
    repeat (6) @(posedge clk);
    dpulse(0);
    repeat (8) @(posedge clk);
    #1 chk(dgnt, 4'h0);
    @(posedge clk) peer_d <= 1'b0;
    wait_g(5'h01);
    $display("priority line test done");
  endtask

  task automatic t_core();
    @(posedge clk) slow <= 1'b1;
    core_req <= 1'b1;
    wait_g(5'h10);
    chk(cpo, 1'b1);
    @(posedge clk) core_req <= 1'b0;
    wait_g(5'h00);
    slow <= 1'b0;
    $display("core access test done");
  endtask

  initial begin
    rst_n = 1'b0;
    idx = 3'h1;
    master = 1'b1;
    hreq_n = 1'b1;
    core_req = 1'b0;
    slow = 1'b0;
    peer_c = 1'b0;
    peer_d = 1'b0;
    dreq_n = 4'hF;
    do_reset(3'h1);
    t_slave();
    t_host();
    t_dma();
    t_prio();
    t_core();
    do_reset(3'h0);
    t_host();
    end_sim();
  end
endmodule
`default_nettype wire
